// ---- core/acc_pkg.sv ----
// constants, register map and encodings for the analog comparator control block
// assumes a single 100 MHz system clock and a 32-bit AXI4-Lite register port
package acc_pkg;

  // -------------------------------------------------------------
  // register byte addresses
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_CONV_CTRL_B = 8'h00;
  localparam logic [7:0] ADDR_CMP_CTRL_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DIG_IN_DISABLE = 8'h08;

  // -------------------------------------------------------------
  // converter_control_b fields
  // -------------------------------------------------------------
  localparam int CCB_MUX_EN = 6;
  localparam int CCB_REF_DIV_LO = 4;
  localparam int CCB_TRIG_LO = 0;

  // -------------------------------------------------------------
  // comparator_control_status fields
  // -------------------------------------------------------------
  localparam int CCS_PWR_OFF = 7;
  localparam int CCS_INT_REF = 6;
  localparam int CCS_RESULT = 5;
  localparam int CCS_FLAG = 4;
  localparam int CCS_IRQ_EN = 3;
  localparam int CCS_CAP_ROUTE = 2;
  localparam int CCS_MODE_LO = 0;

  // -------------------------------------------------------------
  // digital_input_disable_0 fields
  // -------------------------------------------------------------
  localparam int DID_POS_OFF = 7;
  localparam int DID_NEG_OFF = 6;

  // -------------------------------------------------------------
  // encodings and reset values
  // -------------------------------------------------------------
  localparam logic [4:0] CHAN_LAST = 5'h0A;
  localparam logic [1:0] REF_SRC_INTERNAL = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] REG8_RESET = 8'h00;

  typedef enum logic [1:0] {
    ACC_EV_TOGGLE = 2'b00,
    ACC_EV_RSVD = 2'b01,
    ACC_EV_FALL = 2'b10,
    ACC_EV_RISE = 2'b11
  } acc_evmode_e;

endpackage

// ---- core/acc_top.sv ----
// digital control around an on-chip analog comparator: input selection,
// synchronisation, event detection, interrupt, capture route, pin buffers
// assumes the analog core gives a raw compare level, and that the converter
// enable, channel select and reference source come from same-clock logic
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module acc_top (
  input wire logic CLK,
  input wire logic SRST,
  // axi4-lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // analog core and neighbours
  input wire logic CMP_RAW,
  input wire logic CONVERTER_ON,
  input wire logic [4:0] CHANNEL_SELECT,
  input wire logic [1:0] REFERENCE_SOURCE_SELECT,
  input wire logic VECTOR_ACK,
  input wire logic POS_PIN_DIG,
  input wire logic NEG_PIN_DIG,
  output logic CMP_POWER_OFF,
  output logic POS_FROM_MUX,
  output logic [3:0] POS_CHANNEL,
  output logic NEG_FROM_REF,
  output logic [1:0] REF_DIVIDER_SELECT,
  output logic CAPTURE_IN,
  output logic POS_PIN_BUFFER_OFF,
  output logic NEG_PIN_BUFFER_OFF,
  output logic POS_PIN_PORT_BIT,
  output logic NEG_PIN_PORT_BIT,
  output logic CMP_IRQ
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // byte-lane-0 register hit; the same decode serves reads and writes
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == acc_pkg::ADDR_CONV_CTRL_B) || (a == acc_pkg::ADDR_CMP_CTRL_STATUS) ||
                  (a == acc_pkg::ADDR_DIG_IN_DISABLE);
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane0_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic mux_en_r;
  logic [1:0] ref_div_r;
  logic [2:0] trig_src_r;
  logic pwr_off_r, int_ref_r, irq_en_r, cap_route_r, flag_r, flag_nxt;
  logic [1:0] ev_mode_r;
  logic [7:0] did_r;
  logic raw_s1_r, raw_s2_r, cmp_result, prev_r;
  logic pos_s1_r, pos_s2_r, neg_s1_r, neg_s2_r;
  logic pos_port_r, neg_port_r, capture_r;
  logic pos_mux_r, neg_ref_r;
  logic [3:0] pos_chan_r;
  logic wr_fire, wr_ccb, wr_ccs, wr_did, event_hit, flag_clear;
  logic [7:0] ccb_view, ccs_view, rd_byte;

  // -------------------------------------------------------------
  // axi4-lite write channel
  // -------------------------------------------------------------
  // address and data are parked separately so they may arrive in any order
  assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
  assign S_AXI_WREADY = !w_held_r && !bvalid_r;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_r <= 1'b1;
      w_data_r <= S_AXI_WDATA[7:0];
      w_lane0_r <= S_AXI_WSTRB[0];
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // response one cycle after both halves are parked
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bvalid_r <= 1'b0;
      bresp_r <= acc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= addr_mapped(aw_addr_r) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // only lane 0 carries register bits; a write without it stores nothing
  assign wr_ccb = wr_fire && w_lane0_r && (aw_addr_r == acc_pkg::ADDR_CONV_CTRL_B);
  assign wr_ccs = wr_fire && w_lane0_r && (aw_addr_r == acc_pkg::ADDR_CMP_CTRL_STATUS);
  assign wr_did = wr_fire && w_lane0_r && (aw_addr_r == acc_pkg::ADDR_DIG_IN_DISABLE);

  // -------------------------------------------------------------
  // axi4-lite read channel
  // -------------------------------------------------------------
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // bipolar bit and reserved bit 3 read as zero here
  assign ccb_view = {1'b0, mux_en_r, ref_div_r, 1'b0, trig_src_r};
  assign ccs_view = {pwr_off_r, int_ref_r, cmp_result, flag_r, irq_en_r, cap_route_r, ev_mode_r};

  always_comb begin
    case (S_AXI_ARADDR)
      acc_pkg::ADDR_CONV_CTRL_B: rd_byte = ccb_view;
      acc_pkg::ADDR_CMP_CTRL_STATUS: rd_byte = ccs_view;
      acc_pkg::ADDR_DIG_IN_DISABLE: rd_byte = did_r;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= acc_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h000000, rd_byte};
      rresp_r <= addr_mapped(S_AXI_ARADDR) ? acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mux_en_r <= 1'b0;
      ref_div_r <= 2'h0;
      trig_src_r <= 3'h0;
    end else if (wr_ccb) begin
      mux_en_r <= w_data_r[acc_pkg::CCB_MUX_EN];
      ref_div_r <= w_data_r[acc_pkg::CCB_REF_DIV_LO +: 2];
      trig_src_r <= w_data_r[acc_pkg::CCB_TRIG_LO +: 3];
    end
  end

  // power-off may be written at any time; no interlock on a live enable
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pwr_off_r <= 1'b0;
      int_ref_r <= 1'b0;
      irq_en_r <= 1'b0;
      cap_route_r <= 1'b0;
      ev_mode_r <= acc_pkg::ACC_EV_TOGGLE;
    end else if (wr_ccs) begin
      pwr_off_r <= w_data_r[acc_pkg::CCS_PWR_OFF];
      int_ref_r <= w_data_r[acc_pkg::CCS_INT_REF];
      irq_en_r <= w_data_r[acc_pkg::CCS_IRQ_EN];
      cap_route_r <= w_data_r[acc_pkg::CCS_CAP_ROUTE];
      ev_mode_r <= w_data_r[acc_pkg::CCS_MODE_LO +: 2];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      did_r <= acc_pkg::REG8_RESET;
    end else if (wr_did) begin
      did_r <= w_data_r;
    end
  end

  // -------------------------------------------------------------
  // comparator output synchroniser
  // -------------------------------------------------------------
  // two flops, then the gated result; the analog core asserts CMP_RAW
  // when the positive input is above the negative one
  always_ff @(posedge CLK) begin
    if (SRST) begin
      raw_s1_r <= 1'b0;
      raw_s2_r <= 1'b0;
    end else begin
      raw_s1_r <= CMP_RAW;
      raw_s2_r <= raw_s1_r;
    end
  end

  // gate kept after the second flop so the status bit lags only by the synchroniser
  assign cmp_result = raw_s2_r && !pwr_off_r;

  // a powered-off comparator reads zero, which can itself look like an edge
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= cmp_result;
    end
  end

  // -------------------------------------------------------------
  // event detection and flag
  // -------------------------------------------------------------
  always_comb begin
    case (acc_pkg::acc_evmode_e'(ev_mode_r))
      acc_pkg::ACC_EV_TOGGLE: event_hit = cmp_result != prev_r;
      acc_pkg::ACC_EV_FALL: event_hit = prev_r && !cmp_result;
      acc_pkg::ACC_EV_RISE: event_hit = !prev_r && cmp_result;
      default: event_hit = 1'b0;
    endcase
  end

  assign flag_clear = VECTOR_ACK || (wr_ccs && w_data_r[acc_pkg::CCS_FLAG]);

  // a new event beats a clear in the same cycle
  always_comb begin
    if (event_hit) begin
      flag_nxt = 1'b1;
    end else if (flag_clear) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // level request; the processor applies its global enable itself
  assign CMP_IRQ = flag_r && irq_en_r;

  // -------------------------------------------------------------
  // input selection and capture route
  // -------------------------------------------------------------
  // unsupported channel codes fall back to the positive pin
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pos_mux_r <= 1'b0;
      pos_chan_r <= 4'h0;
      neg_ref_r <= 1'b0;
      capture_r <= 1'b0;
    end else begin
      pos_mux_r <= mux_en_r && !CONVERTER_ON && (CHANNEL_SELECT <= acc_pkg::CHAN_LAST);
      pos_chan_r <= CHANNEL_SELECT[3:0];
      neg_ref_r <= int_ref_r && (REFERENCE_SOURCE_SELECT == acc_pkg::REF_SRC_INTERNAL);
      capture_r <= cap_route_r && cmp_result;
    end
  end

  assign CMP_POWER_OFF = pwr_off_r;
  assign POS_FROM_MUX = pos_mux_r;
  assign POS_CHANNEL = pos_chan_r;
  assign NEG_FROM_REF = neg_ref_r;
  assign REF_DIVIDER_SELECT = ref_div_r;
  assign CAPTURE_IN = capture_r;

  // -------------------------------------------------------------
  // pin digital input buffers
  // -------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pos_s1_r <= 1'b0;
      pos_s2_r <= 1'b0;
      neg_s1_r <= 1'b0;
      neg_s2_r <= 1'b0;
      pos_port_r <= 1'b0;
      neg_port_r <= 1'b0;
    end else begin
      pos_s1_r <= POS_PIN_DIG;
      pos_s2_r <= pos_s1_r;
      neg_s1_r <= NEG_PIN_DIG;
      neg_s2_r <= neg_s1_r;
      pos_port_r <= pos_s2_r && !did_r[acc_pkg::DID_POS_OFF];
      neg_port_r <= neg_s2_r && !did_r[acc_pkg::DID_NEG_OFF];
    end
  end

  assign POS_PIN_BUFFER_OFF = did_r[acc_pkg::DID_POS_OFF];
  assign NEG_PIN_BUFFER_OFF = did_r[acc_pkg::DID_NEG_OFF];
  assign POS_PIN_PORT_BIT = pos_port_r;
  assign NEG_PIN_PORT_BIT = neg_port_r;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  a_result_follows_raw: assert property (@(posedge CLK) disable iff (SRST)
    !pwr_off_r && !$past(SRST) && !$past(SRST, 2) |-> cmp_result == $past(CMP_RAW, 2))
    else $error("result does not follow raw compare after two cycles");

  a_power_off_zero: assert property (@(posedge CLK) disable iff (SRST)
    pwr_off_r |=> !CAPTURE_IN)
    else $error("powered-off comparator reached the capture input");

  a_rise_sets_flag: assert property (@(posedge CLK) disable iff (SRST)
    (ev_mode_r == acc_pkg::ACC_EV_RISE) && cmp_result && !prev_r |=> flag_r)
    else $error("rising edge did not set flag");

  a_reserved_no_set: assert property (@(posedge CLK) disable iff (SRST)
    (ev_mode_r == acc_pkg::ACC_EV_RSVD) && !flag_r |=> !flag_r)
    else $error("reserved mode set the flag");

  a_fall_only_down: assert property (@(posedge CLK) disable iff (SRST)
    (ev_mode_r == acc_pkg::ACC_EV_FALL) && !flag_r ##1 flag_r |-> $past(prev_r) && !$past(cmp_result))
    else $error("falling mode flagged without a falling edge");

  a_ack_clears: assert property (@(posedge CLK) disable iff (SRST)
    VECTOR_ACK && !event_hit |=> !flag_r)
    else $error("vector acknowledge left flag set");

  a_zero_write_keeps: assert property (@(posedge CLK) disable iff (SRST)
    flag_r && wr_ccs && !w_data_r[acc_pkg::CCS_FLAG] && !VECTOR_ACK |=> flag_r)
    else $error("writing zero cleared the flag");

  a_irq_gating: assert property (@(posedge CLK) disable iff (SRST)
    wr_ccs && !w_data_r[acc_pkg::CCS_IRQ_EN] |=> !CMP_IRQ)
    else $error("interrupt request survives clearing its enable");

  a_capture_route: assert property (@(posedge CLK) disable iff (SRST)
    !cap_route_r |=> !CAPTURE_IN)
    else $error("capture input driven while route is off");

  a_mux_select: assert property (@(posedge CLK) disable iff (SRST)
    CONVERTER_ON || !mux_en_r |=> !POS_FROM_MUX)
    else $error("multiplexer used while converter on or disabled");

  a_pin_disable: assert property (@(posedge CLK) disable iff (SRST)
    did_r[acc_pkg::DID_POS_OFF] |=> !POS_PIN_PORT_BIT)
    else $error("disabled positive pin reads one");

endmodule

// ---- dv/acc_cmp_model.sv ----
// behavioural analog core: compares the selected positive and negative inputs
// assumes millivolt levels from the bench and the selection outputs of the block
`timescale 1ns/1ps
module acc_cmp_model (
  input wire logic pos_from_mux,
  input wire logic [3:0] pos_channel,
  input wire logic neg_from_ref,
  input wire logic [1:0] ref_div,
  input wire logic [15:0] pos_pin_mv,
  input wire logic [15:0] neg_pin_mv,
  output logic cmp_raw
);
  logic [15:0] pos_sel_mv;
  logic [15:0] neg_sel_mv;
  // each converter channel sits at 200 mV times its number; power-off is left to the block,
  // so a block that fails to gate the result is seen
  always_comb begin
    pos_sel_mv = pos_from_mux ? 16'(200 * pos_channel) : pos_pin_mv;
    neg_sel_mv = neg_from_ref ? (16'd2560 >> ref_div) : neg_pin_mv;
    cmp_raw = pos_sel_mv > neg_sel_mv;
  end
endmodule

// ---- dv/analog_comparator_control_test.sv ----
// self-checking bench for the comparator control block
// assumes the block answers on AXI4-Lite and the analog core is the behavioural model
`timescale 1ns/1ps
module analog_comparator_control_test;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] resp;} acc_row_s;
  logic clk, srst, aw_valid, w_valid, b_ready, ar_valid, r_ready, aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [7:0] aw_addr, ar_addr, v;
  logic [31:0] w_data, r_data;
  logic [3:0] w_strb, pos_chan;
  logic [1:0] b_resp, r_resp, ref_src, ref_div, rsp;
  logic cmp_raw, conv_on, vec_ack, pos_dig, neg_dig, pwr_off, pos_mux, neg_ref, cap_in;
  logic pos_boff, neg_boff, pos_port, neg_port, irq;
  logic [4:0] chan;
  logic [15:0] pos_mv, neg_mv;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  acc_row_s rows [8];

  acc_top uut (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
    .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
    .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .CMP_RAW(cmp_raw),
    .CONVERTER_ON(conv_on), .CHANNEL_SELECT(chan), .REFERENCE_SOURCE_SELECT(ref_src),
    .VECTOR_ACK(vec_ack), .POS_PIN_DIG(pos_dig), .NEG_PIN_DIG(neg_dig), .CMP_POWER_OFF(pwr_off),
    .POS_FROM_MUX(pos_mux), .POS_CHANNEL(pos_chan), .NEG_FROM_REF(neg_ref),
    .REF_DIVIDER_SELECT(ref_div), .CAPTURE_IN(cap_in), .POS_PIN_BUFFER_OFF(pos_boff),
    .NEG_PIN_BUFFER_OFF(neg_boff), .POS_PIN_PORT_BIT(pos_port), .NEG_PIN_PORT_BIT(neg_port), .CMP_IRQ(irq));

  acc_cmp_model core (.pos_from_mux(pos_mux), .pos_channel(pos_chan), .neg_from_ref(neg_ref),
    .ref_div(ref_div), .pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv), .cmp_raw(cmp_raw));

  // --------------------------------------------------
  // clock, timeout and checking helpers
  // --------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the whole run needs a few hundred cycles; twenty thousand means a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait n edges, then let that edge's updates land
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // --------------------------------------------------
  // bus master: handshakes judged on values settled before the edge
  // --------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    b_hs = 1'b0;
    @(posedge clk);
    aw_addr <= a; aw_valid <= 1'b1; w_data <= {24'h0, d}; w_strb <= 4'hF; w_valid <= 1'b1; b_ready <= 1'b1;
    while (!b_hs) begin
      #1;
      aw_hs = aw_valid && aw_ready;
      w_hs = w_valid && w_ready;
      b_hs = b_valid && b_ready;
      r = b_resp;
      @(posedge clk);
      if (aw_hs) aw_valid <= 1'b0;
      if (w_hs) w_valid <= 1'b0;
      if (b_hs) b_ready <= 1'b0;
    end
    #1;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    @(posedge clk);
    ar_addr <= a; ar_valid <= 1'b1; r_ready <= 1'b1;
    while (!r_hs) begin
      #1;
      ar_hs = ar_valid && ar_ready;
      r_hs = r_valid && r_ready;
      d = r_data[7:0];
      r = r_resp;
      @(posedge clk);
      if (ar_hs) ar_valid <= 1'b0;
      if (r_hs) r_ready <= 1'b0;
    end
    #1;
  endtask

  task automatic wcs(input logic [7:0] d);
    axi_write(acc_pkg::ADDR_CMP_CTRL_STATUS, d, rsp);
  endtask

  task automatic rcs();
    axi_read(acc_pkg::ADDR_CMP_CTRL_STATUS, v, rsp);
  endtask

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    srst = 1'b1; aw_valid = 1'b0; w_valid = 1'b0; b_ready = 1'b0; ar_valid = 1'b0; r_ready = 1'b0;
    aw_addr = 8'h00; ar_addr = 8'h00; w_data = 32'h0; w_strb = 4'h0; conv_on = 1'b0; chan = 5'h00;
    ref_src = 2'h0; vec_ack = 1'b0; pos_dig = 1'b1; neg_dig = 1'b1; pos_mv = 16'd0; neg_mv = 16'd500;
    rows = '{'{8'h00, 8'hFF, 8'h77, 2'h0}, '{8'h00, 8'h00, 8'h00, 2'h0}, '{8'h04, 8'h4C, 8'h4C, 2'h0},
      '{8'h04, 8'h00, 8'h00, 2'h0}, '{8'h08, 8'hFF, 8'hFF, 2'h0}, '{8'h08, 8'h00, 8'h00, 2'h0},
      '{8'h0C, 8'hFF, 8'h00, 2'h2}, '{8'h40, 8'h5A, 8'h00, 2'h2}};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // every register starts at zero
    for (int i = 0; i < 3; i++) begin
      axi_read(8'(4 * i), v, rsp);
      chk(32'(v), 32'h0);
    end
    // register table, unmapped places among it
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].w, rsp);
      chk(32'(rsp), 32'(rows[i].resp));
      axi_read(rows[i].a, v, rsp);
      chk(32'(v), 32'(rows[i].r));
      chk(32'(rsp), 32'(rows[i].resp));
    end
    // synchroniser latency seen through the capture route
    wcs(8'h14);
    @(posedge clk);
    pos_mv <= 16'd1000;
    wt(2);
    chk(32'(cap_in), 32'h0);
    wt(1);
    chk(32'(cap_in), 32'h1);
    wcs(8'h10);
    wt(2);
    chk(32'(cap_in), 32'h0);
    @(posedge clk);
    pos_mv <= 16'd0;
    wt(8);
    // each event mode against a rise and a fall, interrupt held off while the mode changes
    for (int m = 0; m < 4; m++) begin
      wcs(8'h10 | 8'(m));
      @(posedge clk);
      pos_mv <= 16'd1000;
      wt(8);
      rcs();
      chk(32'(v[5]), 32'h1);
      chk(32'(v[4]), 32'(m == 0 || m == 3));
      wcs(8'h10 | 8'(m));
      @(posedge clk);
      pos_mv <= 16'd0;
      wt(8);
      rcs();
      chk(32'(v[4]), 32'(m == 0 || m == 2));
    end
    // request, mask, zero write, vector clear
    wcs(8'h1B);
    @(posedge clk);
    pos_mv <= 16'd1000;
    wt(8);
    chk(32'(irq), 32'h1);
    wcs(8'h03);
    chk(32'(irq), 32'h0);
    rcs();
    chk(32'(v[4]), 32'h1);
    wcs(8'h0B);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    vec_ack <= 1'b1;
    @(posedge clk);
    vec_ack <= 1'b0;
    wt(2);
    chk(32'(irq), 32'h0);
    rcs();
    chk(32'(v[4]), 32'h0);
    wcs(8'h13);
    // power-off gates the result
    wcs(8'h90);
    wt(8);
    chk(32'(pwr_off), 32'h1);
    rcs();
    chk(32'(v[5]), 32'h0);
    wcs(8'h10);
    // converter channels on the positive input, one code past the last
    pos_mv <= 16'd0;
    axi_write(acc_pkg::ADDR_CONV_CTRL_B, 8'h40, rsp);
    for (int c = 0; c < 12; c++) begin
      @(posedge clk);
      chan <= 5'(c);
      wt(8);
      chk(32'(pos_mux), 32'(c <= 10));
      if (c <= 10) chk(32'(pos_chan), 32'(c));
      rcs();
      chk(32'(v[5]), 32'(c >= 3 && c <= 10));
    end
    @(posedge clk);
    chan <= 5'h05;
    conv_on <= 1'b1;
    wt(8);
    chk(32'(pos_mux), 32'h0);
    // internal divided reference on the negative input
    @(posedge clk);
    pos_mv <= 16'd1000; neg_mv <= 16'd3000; ref_src <= 2'h3;
    wcs(8'h50);
    for (int d = 0; d < 4; d++) begin
      axi_write(acc_pkg::ADDR_CONV_CTRL_B, 8'(d << 4), rsp);
      wt(8);
      chk(32'(neg_ref), 32'h1);
      chk(32'(ref_div), 32'(d));
      rcs();
      chk(32'(v[5]), 32'(d >= 2));
    end
    @(posedge clk);
    ref_src <= 2'h1;
    wt(4);
    chk(32'(neg_ref), 32'h0);
    // pin buffers off force the port bits low
    axi_write(acc_pkg::ADDR_DIG_IN_DISABLE, 8'h80, rsp);
    wt(4);
    chk({pos_boff, neg_boff, pos_port, neg_port}, 32'h9);
    axi_write(acc_pkg::ADDR_DIG_IN_DISABLE, 8'hC0, rsp);
    wt(4);
    chk({pos_boff, neg_boff, pos_port, neg_port}, 32'hC);
    // positive buffer back on: its port bit follows the pin again
    axi_write(acc_pkg::ADDR_DIG_IN_DISABLE, 8'h40, rsp);
    wt(2);
    chk(32'({pos_boff, neg_boff, pos_port, neg_port}), 32'h6);
    @(posedge clk);
    pos_dig <= 1'b0;
    wt(4);
    chk(32'({pos_boff, neg_boff, pos_port, neg_port}), 32'h4);
    // second reset in mid-run clears the registers
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    axi_read(acc_pkg::ADDR_DIG_IN_DISABLE, v, rsp);
    chk(32'(v), 32'h0);
    chk(32'({pwr_off, pos_mux, neg_ref, cap_in, irq, pos_boff, neg_boff}), 32'h0);
    give_verdict();
  end
endmodule
